/* File: asc_pkg.sv */
// Shared constants and types for the converter start and sequencing control
package asc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_START_DIV = 8'h10;
  localparam logic [7:0] OFF_SCAN_DIV = 8'h14;
  localparam logic [7:0] OFF_CHAN_GAIN = 8'h18;
  localparam logic [7:0] OFF_ACQ_CTRL = 8'h38;

  // Acquisition control field positions
  localparam int CTRL_GAIN_LSB = 0;
  localparam int CTRL_LAST_LSB = 4;
  localparam int CTRL_SEQ_LSB = 8;
  localparam int CTRL_START_BIT = 16;
  localparam int CTRL_SCAN_BIT = 18;
  localparam int STAT_RUN_BIT = 20;
  localparam int STAT_ARM_BIT = 21;
  localparam int STAT_SCAN_BIT = 22;

  // Reset values
  localparam logic [31:0] RST_START_DIV = 32'h0000_0000;
  localparam logic [31:0] RST_SCAN_DIV = 32'h0000_0000;
  localparam logic [31:0] RST_CHAN_GAIN = 32'h0000_0000;
  localparam logic [31:0] RST_ACQ_CTRL = 32'h0000_0000;

  // Edge select encoding
  localparam logic EDGE_RISE = 1'b0;

  typedef enum logic [1:0] {
    SEQ_NONE = 2'b00,
    SEQ_MODIFY = 2'b01,
    SEQ_ADV = 2'b10,
    SEQ_BASIC = 2'b11
  } asc_seq_t;

  typedef enum logic [0:0] {
    SCAN_IDLE = 1'b0,
    SCAN_RUN = 1'b1
  } asc_scan_t;

  // One conversion request to the converter front end
  typedef struct packed {
    logic start;
    logic [2:0] chan;
    logic [3:0] gain;
  } asc_conv_t;
endpackage

/* File: asc_seq_ctrl.sv */
// Converter start sources, channel sequencing and scan pacing
// What this block does
// - Two-bit sequence mode selects none, modify-basic, advanced or basic sequencing.
// - Mode 00 converts the last-channel field at the common gain.
// - Mode 01 takes setting changes without restarting the channel cycle.
// - Mode 10 steps channels zero to last with per-channel gains, then wraps.
// - Mode 11 steps channels zero to last with common gain, then wraps.
// - Divisor zero: control write with bit 16 gives exactly one start.
// - Divisor nonzero, trigger off: bit 16 write starts now, then periodically.
// - Divisor nonzero, trigger on: bit 16 write arms; trigger edge begins starts.
// - Periodic collection runs until bit 16 written clear or reset.
// - External start input gives one start per selected edge.
// - Bit 18 clear: one channel per start event, nothing more.
// - Bit 18 set: each start converts channels zero to last, then idles.
// - Channels inside a scan are paced by the scan divisor.
// - Bit 18 counts as zero in mode 00 or with last channel zero.
// - Periodic start rate is base clock divided by start divisor.
// - Each nybble of the gain register is its channel's gain code.
module asc_seq_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Secondary function setup from the digital I/O block
  input wire logic trig_en,
  input wire logic trig_edge,
  input wire logic xstart_en,
  input wire logic xstart_edge,
  // Pins
  input wire logic trig_pin,
  input wire logic xstart_pin,
  // Converter request
  output asc_pkg::asc_conv_t conv,
  // Status
  output logic run_active,
  output logic run_armed
);
  logic [31:0] start_div_q, scan_div_q, gain_q, ctrl_q;
  logic [31:0] tmr_q, scan_cnt_q;
  logic [31:0] rdata_q;
  logic rvalid_q, running_q, armed_q, imm_start_q;
  logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [2:0] chan_ptr_q;
  asc_pkg::asc_scan_t state_q;
  asc_pkg::asc_conv_t conv_q;

  logic ctrl_wr, wr_start, tick, scan_en, start_evt, trig_hit, xstart_hit, scan_step;
  logic [1:0] pin_rise, pin_fall;
  logic [2:0] last_ch, com_gain;
  asc_pkg::asc_seq_t seq, wr_seq;

  assign ctrl_wr = reg_wr && (reg_addr == asc_pkg::OFF_ACQ_CTRL);
  assign wr_start = reg_wdata[asc_pkg::CTRL_START_BIT];
  assign seq = asc_pkg::asc_seq_t'(ctrl_q[asc_pkg::CTRL_SEQ_LSB +: 2]);
  assign wr_seq = asc_pkg::asc_seq_t'(reg_wdata[asc_pkg::CTRL_SEQ_LSB +: 2]);
  assign last_ch = ctrl_q[asc_pkg::CTRL_LAST_LSB +: 3];
  assign com_gain = ctrl_q[asc_pkg::CTRL_GAIN_LSB +: 3];
  // Scan bit only counts with a real sequence to walk
  assign scan_en = ctrl_q[asc_pkg::CTRL_SCAN_BIT] && (seq != asc_pkg::SEQ_NONE)
                   && (last_ch != 3'h0);

  // Gain code for a channel under the current mode
  function automatic logic [3:0] gain_for(input logic [2:0] ch, input asc_pkg::asc_seq_t m,
                                          input logic [31:0] g, input logic [2:0] cg);
    if (m == asc_pkg::SEQ_ADV) begin
      return g[{ch, 2'b00} +: 4];
    end
    return {1'b0, cg};
  endfunction

  // Register file
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_div_q <= asc_pkg::RST_START_DIV;
      scan_div_q <= asc_pkg::RST_SCAN_DIV;
      gain_q <= asc_pkg::RST_CHAN_GAIN;
      ctrl_q <= asc_pkg::RST_ACQ_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        asc_pkg::OFF_START_DIV: start_div_q <= reg_wdata;
        asc_pkg::OFF_SCAN_DIV: scan_div_q <= reg_wdata;
        asc_pkg::OFF_CHAN_GAIN: gain_q <= reg_wdata;
        asc_pkg::OFF_ACQ_CTRL: ctrl_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read path, one cycle latency, unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          asc_pkg::OFF_START_DIV: rdata_q <= start_div_q;
          asc_pkg::OFF_SCAN_DIV: rdata_q <= scan_div_q;
          asc_pkg::OFF_CHAN_GAIN: rdata_q <= gain_q;
          asc_pkg::OFF_ACQ_CTRL: begin
            rdata_q <= ctrl_q;
            rdata_q[asc_pkg::STAT_RUN_BIT] <= running_q;
            rdata_q[asc_pkg::STAT_ARM_BIT] <= armed_q;
            rdata_q[asc_pkg::STAT_SCAN_BIT] <= (state_q == asc_pkg::SCAN_RUN);
          end
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin synchronisers; bit 0 trigger, bit 1 external start
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
      pin_s3_q <= 2'b00;
    end else begin
      pin_s1_q <= {xstart_pin, trig_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_rise = pin_s2_q & ~pin_s3_q;
  assign pin_fall = ~pin_s2_q & pin_s3_q;
  assign trig_hit = (trig_edge == asc_pkg::EDGE_RISE) ? pin_rise[0] : pin_fall[0];
  assign xstart_hit = (xstart_edge == asc_pkg::EDGE_RISE) ? pin_rise[1] : pin_fall[1];

  // Software start, arming and run state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      running_q <= 1'b0;
      armed_q <= 1'b0;
      imm_start_q <= 1'b0;
    end else begin
      imm_start_q <= 1'b0;
      if (ctrl_wr) begin
        if (!wr_start) begin
          running_q <= 1'b0;
          armed_q <= 1'b0;
        end else if (start_div_q == 32'h0000_0000) begin
          imm_start_q <= 1'b1;
          running_q <= 1'b0;
          armed_q <= 1'b0;
        end else if (trig_en) begin
          armed_q <= 1'b1;
          running_q <= 1'b0;
        end else begin
          running_q <= 1'b1;
          imm_start_q <= 1'b1;
        end
      end else if (armed_q && trig_hit) begin
        armed_q <= 1'b0;
        running_q <= 1'b1;
        imm_start_q <= 1'b1;
      end
    end
  end

  // Periodic timer; restarts on the immediate start so the first gap is a full period
  assign tick = running_q && !imm_start_q && (start_div_q != 32'h0000_0000)
                && ((tmr_q + 32'd1) >= start_div_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmr_q <= 32'h0000_0000;
    end else if (!running_q || imm_start_q || tick) begin
      tmr_q <= 32'h0000_0000;
    end else begin
      tmr_q <= tmr_q + 32'd1;
    end
  end

  assign start_evt = imm_start_q || tick || (xstart_en && xstart_hit);
  // A zero scan divisor paces at one channel per cycle
  assign scan_step = (scan_cnt_q + 32'd1) >= scan_div_q;

  // Channel sequencing and scan walk; starts during a scan are dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= asc_pkg::SCAN_IDLE;
      chan_ptr_q <= 3'h0;
      scan_cnt_q <= 32'h0000_0000;
      conv_q <= '0;
    end else begin
      conv_q.start <= 1'b0;
      if (ctrl_wr && wr_seq != asc_pkg::SEQ_MODIFY) begin
        state_q <= asc_pkg::SCAN_IDLE;
        chan_ptr_q <= 3'h0;
      end else begin
        case (state_q)
          asc_pkg::SCAN_IDLE: begin
            if (start_evt && scan_en) begin
              conv_q <= '{start: 1'b1, chan: 3'h0,
                          gain: gain_for(3'h0, seq, gain_q, com_gain)};
              chan_ptr_q <= 3'h1;
              scan_cnt_q <= 32'h0000_0000;
              state_q <= asc_pkg::SCAN_RUN;
            end else if (start_evt && seq == asc_pkg::SEQ_NONE) begin
              conv_q <= '{start: 1'b1, chan: last_ch, gain: {1'b0, com_gain}};
            end else if (start_evt) begin
              conv_q <= '{start: 1'b1, chan: chan_ptr_q,
                          gain: gain_for(chan_ptr_q, seq, gain_q, com_gain)};
              // Modify-basic keeps the pointer across setting writes
              chan_ptr_q <= (chan_ptr_q >= last_ch) ? 3'h0
                            : chan_ptr_q + 3'h1;
            end
          end
          asc_pkg::SCAN_RUN: begin
            if (scan_step) begin
              conv_q <= '{start: 1'b1, chan: chan_ptr_q,
                          gain: gain_for(chan_ptr_q, seq, gain_q, com_gain)};
              scan_cnt_q <= 32'h0000_0000;
              if (chan_ptr_q >= last_ch) begin
                chan_ptr_q <= 3'h0;
                state_q <= asc_pkg::SCAN_IDLE;
              end else begin
                chan_ptr_q <= chan_ptr_q + 3'h1;
              end
            end else begin
              scan_cnt_q <= scan_cnt_q + 32'd1;
            end
          end
          default: state_q <= asc_pkg::SCAN_IDLE;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign conv = conv_q;
  assign run_active = running_q;
  assign run_armed = armed_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_sw_single_start: assert property (ctrl_wr && wr_start
    && start_div_q == 32'h0000_0000 |=> imm_start_q && !running_q ##1 !imm_start_q)
    else $error("single software start wrong");
  a_periodic_soft_go: assert property (ctrl_wr && wr_start
    && start_div_q != 32'h0000_0000 && !trig_en |=> running_q && imm_start_q)
    else $error("periodic software start missing");
  a_arm_only: assert property (ctrl_wr && wr_start && start_div_q != 32'h0000_0000
    && trig_en |=> armed_q && !running_q && !imm_start_q)
    else $error("arm produced a start");
  a_trig_wait: assert property (armed_q && !trig_hit && !ctrl_wr
    |=> armed_q && !running_q && !imm_start_q)
    else $error("armed state left without trigger");
  a_stop_on_clear: assert property (ctrl_wr && !wr_start |=> !running_q && !armed_q)
    else $error("collection not stopped");
  a_timer_period: assert property (tick |-> (tmr_q + 32'd1) == start_div_q
    ##1 tmr_q == 32'h0000_0000)
    else $error("timer period wrong");
  a_no_spurious_conv: assert property (state_q == asc_pkg::SCAN_IDLE && !start_evt
    |=> !conv_q.start)
    else $error("conversion without start");
  a_ext_start_conv: assert property (xstart_en && xstart_hit
    && state_q == asc_pkg::SCAN_IDLE && !ctrl_wr |=> conv_q.start)
    else $error("external start lost");
  a_none_mode_chan: assert property (start_evt && !ctrl_wr
    && state_q == asc_pkg::SCAN_IDLE && seq == asc_pkg::SEQ_NONE
    |=> conv_q.chan == $past(last_ch) && conv_q.gain == {1'b0, $past(com_gain)})
    else $error("non-sequenced channel or gain wrong");
  a_adv_gain_pick: assert property (start_evt && !ctrl_wr
    && state_q == asc_pkg::SCAN_IDLE && !scan_en && seq == asc_pkg::SEQ_ADV
    |=> conv_q.chan == $past(chan_ptr_q)
    && conv_q.gain == gain_for($past(chan_ptr_q), asc_pkg::SEQ_ADV, $past(gain_q), 3'h0))
    else $error("advanced gain wrong");
  a_basic_gain_pick: assert property (start_evt && !ctrl_wr
    && state_q == asc_pkg::SCAN_IDLE && seq == asc_pkg::SEQ_BASIC
    |=> conv_q.gain == {1'b0, $past(com_gain)})
    else $error("basic gain wrong");
  a_modify_keeps_ptr: assert property (ctrl_wr && wr_seq == asc_pkg::SEQ_MODIFY
    && state_q == asc_pkg::SCAN_IDLE && !start_evt |=> chan_ptr_q == $past(chan_ptr_q))
    else $error("modify write moved pointer");
  a_scan_first_ch0: assert property (start_evt && !ctrl_wr
    && state_q == asc_pkg::SCAN_IDLE && scan_en
    |=> conv_q.start && conv_q.chan == 3'h0 && state_q == asc_pkg::SCAN_RUN)
    else $error("scan does not begin at channel zero");
  a_scan_ignored: assert property (start_evt && !scan_en
    && state_q == asc_pkg::SCAN_IDLE |=> state_q == asc_pkg::SCAN_IDLE)
    else $error("scan entered while disabled");
  a_scan_pacing: assert property (state_q == asc_pkg::SCAN_RUN
    && !scan_step && !ctrl_wr |=> !conv_q.start)
    else $error("scan channel issued early");

  c_periodic_run: cover property (imm_start_q && running_q ##[1:64] tick);
  c_armed_trigger: cover property (armed_q ##1 running_q);
  c_full_scan: cover property (state_q == asc_pkg::SCAN_RUN
    ##[1:300] state_q == asc_pkg::SCAN_IDLE);
  c_ext_start: cover property (xstart_en && xstart_hit);
  c_modify_write: cover property (ctrl_wr && wr_seq == asc_pkg::SEQ_MODIFY);
endmodule

/* File: asc_conv_model.sv */
// Converter front end model that logs each conversion request
module asc_conv_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request from the sequencer
  input asc_pkg::asc_conv_t conv,
  // Log
  output logic [15:0] conv_cnt,
  output logic [2:0] last_chan,
  output logic [3:0] last_gain,
  output logic [15:0] last_gap
);
  logic [15:0] since_q;
  // Gap is the cycle distance between the last two requests
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      since_q <= 16'h0000;
      conv_cnt <= 16'h0000;
      last_chan <= 3'h0;
      last_gain <= 4'h0;
      last_gap <= 16'h0000;
    end else begin
      since_q <= conv.start ? 16'h0001 : since_q + 16'h0001;
      if (conv.start) begin
        conv_cnt <= conv_cnt + 16'h0001;
        last_chan <= conv.chan;
        last_gain <= conv.gain;
        last_gap <= since_q;
      end
    end
  end
endmodule

/* File: asc_seq_ctrl_tb.sv */
// Self-checking bench for the converter start and sequencing control
module asc_seq_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic reg_rvalid, run_active, run_armed;
  logic trig_en = 1'b0, trig_edge = 1'b0, xstart_en = 1'b0, xstart_edge = 1'b0;
  logic trig_pin = 1'b0, xstart_pin = 1'b0;
  asc_pkg::asc_conv_t conv;
  logic [15:0] conv_cnt, last_gap, c0;
  logic [2:0] last_chan, last, cg, ch;
  logic [3:0] last_gain;
  logic [31:0] rdv, greg, n, sd;
  logic [15:0] lf = 16'h493D;
  logic [7:0] offs [4] = '{asc_pkg::OFF_START_DIV, asc_pkg::OFF_SCAN_DIV,
    asc_pkg::OFF_CHAN_GAIN, asc_pkg::OFF_ACQ_CTRL};
  logic [31:0] rsts [4] = '{asc_pkg::RST_START_DIV, asc_pkg::RST_SCAN_DIV,
    asc_pkg::RST_CHAN_GAIN, asc_pkg::RST_ACQ_CTRL};
  int err_count = 0;
  int tests_run = 0;

  always #20 clk_sys = ~clk_sys;

  asc_seq_ctrl dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .trig_en(trig_en), .trig_edge(trig_edge), .xstart_en(xstart_en),
    .xstart_edge(xstart_edge), .trig_pin(trig_pin), .xstart_pin(xstart_pin), .conv(conv),
    .run_active(run_active), .run_armed(run_armed));
  asc_conv_model model (.clk_sys(clk_sys), .rst(rst), .conv(conv), .conv_cnt(conv_cnt),
    .last_chan(last_chan), .last_gain(last_gain), .last_gap(last_gap));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [2:0] l,
    input logic [2:0] g, input logic s, input logic sc);
    return {13'h0000, sc, 1'b0, s, 6'h00, m, 1'b0, l, 1'b0, g};
  endfunction
  // Only advanced mode takes the per-channel nybble
  function automatic logic [3:0] exp_gain(input logic [1:0] m, input logic [2:0] c,
    input logic [31:0] g, input logic [2:0] cgain);
    return (m == 2'b10) ? g[c * 4 +: 4] : {1'b0, cgain};
  endfunction
  task automatic rnd(output logic [31:0] v);
    lf = lfsr(lf);
    v = {lf, lfsr(lf)};
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    cyc(1);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    chk("read valid", 32'h0000_0001, {31'h0, reg_rvalid});
    d = reg_rdata;
  endtask
  // Pin held six cycles each way so the three sync flops see both edges
  task automatic pulse;
    xstart_pin = 1'b1;
    cyc(6);
    xstart_pin = 1'b0;
    cyc(6);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #800000;
    err_count++;
    wrap_up();
  end

  initial begin
    cyc(12);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(offs[i], rdv);
      chk("reset value", rsts[i], rdv);
    end
    for (int i = 0; i < 3; i++) begin
      rnd(n);
      wr(offs[i], n);
      rd(offs[i], rdv);
      chk("readback", n, rdv);
    end
    rd(8'h20, rdv);
    chk("unmapped read", 32'h0000_0000, rdv);
    $display("test registers done");
    rnd(n);
    last = n[2:0] | 3'h1;
    cg = n[6:4];
    wr(asc_pkg::OFF_START_DIV, 32'h0000_0000);
    c0 = conv_cnt;
    // Scan bit set too: mode 00 must still give one conversion
    wr(asc_pkg::OFF_ACQ_CTRL, ctrl(2'b00, last, cg, 1'b1, 1'b1));
    cyc(20);
    chk("single count", {16'h0, c0 + 16'h0001}, {16'h0, conv_cnt});
    chk("mode00 chan", {29'h0, last}, {29'h0, last_chan});
    chk("mode00 gain", {29'h0, cg}, {28'h0, last_gain});
    $display("test software single done");
    rnd(greg);
    wr(asc_pkg::OFF_CHAN_GAIN, greg);
    xstart_en = 1'b1;
    for (int m = 2; m < 4; m++) begin
      rnd(n);
      last = n[2:0] | 3'h1;
      cg = n[6:4];
      xstart_edge = n[8];
      wr(asc_pkg::OFF_ACQ_CTRL, ctrl(2'(m), last, cg, 1'b0, 1'b0));
      for (int i = 0; i < int'(last) + 2; i++) begin
        ch = 3'(i % (int'(last) + 1));
        c0 = conv_cnt;
        pulse();
        chk("xstart count", {16'h0, c0 + 16'h0001}, {16'h0, conv_cnt});
        chk("seq chan", {29'h0, ch}, {29'h0, last_chan});
        chk("seq gain", {28'h0, exp_gain(2'(m), ch, greg, cg)},
          {28'h0, last_gain});
      end
    end
    // Pointer now sits at channel one; the modify write must keep it
    wr(asc_pkg::OFF_ACQ_CTRL, ctrl(2'b01, last, ~cg, 1'b0, 1'b0));
    pulse();
    chk("modify chan", 32'h0000_0001, {29'h0, last_chan});
    chk("modify gain", {29'h0, ~cg}, {28'h0, last_gain});
    xstart_en = 1'b0;
    $display("test sequencing done");
    rnd(n);
    n = 32'h0000_0002 + n % 32'h0000_0009;
    wr(asc_pkg::OFF_START_DIV, n);
    c0 = conv_cnt;
    wr(asc_pkg::OFF_ACQ_CTRL, ctrl(2'b11, last, cg, 1'b1, 1'b0));
    cyc(1);
    chk("running", 32'h0000_0001, {31'h0, run_active});
    cyc(4 * int'(n));
    chk("periodic count", 32'h0000_0004, {16'h0, conv_cnt - c0});
    chk("periodic gap", n, {16'h0, last_gap});
    rd(asc_pkg::OFF_ACQ_CTRL, rdv);
    chk("status run", 32'h0000_0001, {31'h0, rdv[asc_pkg::STAT_RUN_BIT]});
    wr(asc_pkg::OFF_ACQ_CTRL, ctrl(2'b11, last, cg, 1'b0, 1'b0));
    cyc(2);
    chk("stopped", 32'h0000_0000, {31'h0, run_active});
    c0 = conv_cnt;
    cyc(3 * int'(n));
    chk("no starts after stop", {16'h0, c0}, {16'h0, conv_cnt});
    $display("test periodic done");
    // Falling edge selected; the rising edge while armed must not fire
    trig_en = 1'b1;
    trig_edge = 1'b1;
    wr(asc_pkg::OFF_ACQ_CTRL, ctrl(2'b11, last, cg, 1'b1, 1'b0));
    cyc(1);
    chk("armed", 32'h0000_0001, {31'h0, run_armed});
    rd(asc_pkg::OFF_ACQ_CTRL, rdv);
    chk("status armed", 32'h0000_0001, {31'h0, rdv[asc_pkg::STAT_ARM_BIT]});
    c0 = conv_cnt;
    trig_pin = 1'b1;
    cyc(20);
    chk("armed idle", {16'h0, c0}, {16'h0, conv_cnt});
    chk("armed wait", 32'h0000_0001, {31'h0, run_armed});
    trig_pin = 1'b0;
    cyc(8);
    chk("triggered", 32'h0000_0001, {31'h0, run_active});
    cyc(3 * int'(n));
    chk("trigger gap", n, {16'h0, last_gap});
    // A mid-run reset must stop collection as well
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk("reset stops run", 32'h0000_0000, {30'h0, run_active, run_armed});
    cyc(3 * int'(n));
    chk("no starts after reset", 32'h0000_0000, {16'h0, conv_cnt});
    trig_en = 1'b0;
    $display("test trigger done");
    wr(asc_pkg::OFF_START_DIV, 32'h0000_0000);
    rnd(sd);
    sd = 32'h0000_0002 + sd % 32'h0000_0005;
    wr(asc_pkg::OFF_SCAN_DIV, sd);
    c0 = conv_cnt;
    wr(asc_pkg::OFF_ACQ_CTRL, ctrl(2'b11, last, cg, 1'b1, 1'b1));
    cyc(8 * int'(sd) + 10);
    chk("scan count", {16'h0, c0 + 16'(last) + 16'h0001}, {16'h0, conv_cnt});
    chk("scan last chan", {29'h0, last}, {29'h0, last_chan});
    chk("scan pace", sd, {16'h0, last_gap});
    c0 = conv_cnt;
    wr(asc_pkg::OFF_ACQ_CTRL, ctrl(2'b11, 3'h0, cg, 1'b1, 1'b1));
    cyc(20);
    chk("scan last zero", {16'h0, c0 + 16'h0001}, {16'h0, conv_cnt});
    $display("test scan done");
    wrap_up();
  end
endmodule
